/* src/eeprom_client_defines.svh */
// Constants for the two-wire EEPROM client front end.
`ifndef EEPROM_CLIENT_DEFINES_SVH
`define EEPROM_CLIENT_DEFINES_SVH
`define CLK_MHZ 100
`define WRITE_TIME_MS 5
`define WRITE_CYCLES (`WRITE_TIME_MS * 1000 * `CLK_MHZ)
`define DEV_TYPE_DEFAULT 4'h5
`define BITS_PER_BYTE 4'h8
`define IDLE_BYTE 8'hff
`define FIFO_DEPTH 16
`define FIFO_WIDTH 9
`endif

/* src/eeprom_client_pkg.sv */
// Types shared by the two-wire EEPROM client front end.
package eeprom_client_pkg;
   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_ADDR = 2'b01,
      ST_WRITE = 2'b10,
      ST_READ = 2'b11
   } bus_state_t;
   typedef struct packed {
      logic first;
      logic [7:0] data;
   } rx_word_t;
endpackage

/* src/eeprom_client.sv */
// Two-wire EEPROM client: bus front end with receive FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_client_defines.svh"

// ----------------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------------
module rx_fifo #(
   parameter int WIDTH = `FIFO_WIDTH,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic clk, // System clock.
   input wire logic sys_rst, // Asynchronous reset, active high.
   input wire logic in_valid, // Write strobe.
   output logic in_ready, // Space available.
   input wire logic [WIDTH-1:0] in_data, // Write word.
   output logic out_valid, // Word available.
   input wire logic out_ready, // Read strobe.
   output logic [WIDTH-1:0] out_data // Head word.
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic push, pop;

   always_comb begin
      in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
      out_valid = wr_r != rd_r;
      out_data = mem[rd_r[AW-1:0]];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_nxt = push ? wr_r + 1'b1 : wr_r;
      rd_nxt = pop ? rd_r + 1'b1 : rd_r;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_r[AW-1:0]] <= in_data;
      end
   end
endmodule

// ----------------------------------------------------------------------
// Bus client
// ----------------------------------------------------------------------
module eeprom_client #(
   parameter int WRITE_CYCLES = `WRITE_CYCLES,
   parameter logic [3:0] DEV_TYPE = `DEV_TYPE_DEFAULT // Arbitrary value.
) (
   input wire logic clk, // System clock, 100 MHz.
   input wire logic sys_rst, // Power-on reset, active high.
   input wire logic scl_in, // Bus clock pin level.
   input wire logic sda_in, // Bus data pin level.
   output logic sda_out, // Data pin drive value, always low.
   output logic sda_oe, // High while pulling data low.
   output logic rx_valid, // Received byte available.
   input wire logic rx_ready, // Consumer takes the byte.
   output eeprom_client_pkg::rx_word_t rx_word, // Received byte and first flag.
   input wire logic tx_valid, // Read data offered.
   input wire logic [7:0] tx_data, // Read data byte.
   output logic tx_take, // Pulse: tx_data was consumed.
   output logic write_busy, // Internal write cycle running.
   output logic write_start, // Pulse: write cycle launched.
   output logic standby, // Device in standby.
   output logic read_mode, // Current command is a read.
   output logic [2:0] addr_hi // memory_address_bit_ten..eight.
);
   import eeprom_client_pkg::*;
   localparam int TW = $clog2(WRITE_CYCLES + 1);

   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   logic [2:0] scl_s_r, sda_s_r;
   logic scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt, scl_p_r, sda_p_r;
   logic rise_c, fall_c, start_c, stop_c;

   always_comb begin
      scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
      sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
      rise_c = scl_f_r && !scl_p_r;
      fall_c = !scl_f_r && scl_p_r;
      start_c = scl_f_r && scl_p_r && sda_p_r && !sda_f_r;
      stop_c = scl_f_r && scl_p_r && !sda_p_r && sda_f_r;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_s_r <= 3'h7;
         sda_s_r <= 3'h7;
         scl_f_r <= 1'b1;
         sda_f_r <= 1'b1;
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
      end else begin
         scl_s_r <= {scl_s_r[1:0], scl_in};
         sda_s_r <= {sda_s_r[1:0], sda_in};
         scl_f_r <= scl_f_nxt;
         sda_f_r <= sda_f_nxt;
         scl_p_r <= scl_f_r;
         sda_p_r <= sda_f_r;
      end
   end

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   logic push_r, push_nxt, fifo_ready, fifo_valid, fifo_pop;
   rx_word_t push_word_r, push_word_nxt, fifo_word;
   logic out_valid_r, out_valid_nxt;
   rx_word_t out_word_r, out_word_nxt;

   rx_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(push_r),
      .in_ready(fifo_ready),
      .in_data(push_word_r),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_word)
   );

   // Output stage keeps the top outputs registered.
   always_comb begin
      fifo_pop = fifo_valid && (!out_valid_r || rx_ready);
      out_valid_nxt = out_valid_r && !rx_ready;
      out_word_nxt = out_word_r;
      if (fifo_pop) begin
         out_valid_nxt = 1'b1;
         out_word_nxt = fifo_word;
      end
   end

   // ----------------------------------------------------------------
   // Protocol engine
   // ----------------------------------------------------------------
   bus_state_t state_r, state_nxt;
   logic [3:0] bitcnt_r, bitcnt_nxt;
   logic [7:0] shreg_r, shreg_nxt;
   logic ack_ph_r, ack_ph_nxt, oe_r, oe_nxt, ack_ok_r, ack_ok_nxt;
   logic host_nack_r, host_nack_nxt, rw_r, rw_nxt;
   logic [1:0] nbytes_r, nbytes_nxt;
   logic [2:0] addr_hi_r, addr_hi_nxt;
   logic busy_r, busy_nxt, wstart_r, wstart_nxt, take_r, take_nxt;
   logic [TW-1:0] wcnt_r, wcnt_nxt;
   logic [7:0] tx_byte;

   always_comb begin
      state_nxt = state_r;
      bitcnt_nxt = bitcnt_r;
      shreg_nxt = shreg_r;
      ack_ph_nxt = ack_ph_r;
      oe_nxt = oe_r;
      ack_ok_nxt = ack_ok_r;
      host_nack_nxt = host_nack_r;
      rw_nxt = rw_r;
      nbytes_nxt = nbytes_r;
      addr_hi_nxt = addr_hi_r;
      busy_nxt = busy_r;
      wcnt_nxt = wcnt_r;
      wstart_nxt = 1'b0;
      take_nxt = 1'b0;
      push_nxt = 1'b0;
      push_word_nxt = push_word_r;
      tx_byte = tx_valid ? tx_data : `IDLE_BYTE;
      if (busy_r) begin
         if (wcnt_r == TW'(WRITE_CYCLES - 1)) begin
            busy_nxt = 1'b0;
         end else begin
            wcnt_nxt = wcnt_r + 1'b1;
         end
      end
      if (start_c) begin
         state_nxt = ST_ADDR;
         bitcnt_nxt = '0;
         ack_ph_nxt = 1'b0;
         oe_nxt = 1'b0;
      end else if (stop_c) begin
         if (state_r == ST_WRITE && nbytes_r == 2'h2) begin
            busy_nxt = 1'b1;
            wcnt_nxt = '0;
            wstart_nxt = 1'b1;
         end
         state_nxt = ST_STANDBY;
         ack_ph_nxt = 1'b0;
         oe_nxt = 1'b0;
      end else if (state_r != ST_STANDBY) begin
         if (rise_c) begin
            if (ack_ph_r) begin
               host_nack_nxt = sda_f_r;
            end else begin
               bitcnt_nxt = bitcnt_r + 1'b1;
               if (state_r != ST_READ) begin
                  shreg_nxt = {shreg_r[6:0], sda_f_r};
               end
            end
         end else if (fall_c) begin
            if (!ack_ph_r && bitcnt_r == `BITS_PER_BYTE) begin
               ack_ph_nxt = 1'b1;
               bitcnt_nxt = '0;
               oe_nxt = 1'b0;
               case (state_r)
                  ST_ADDR: begin
                     ack_ok_nxt = shreg_r[7:4] == DEV_TYPE && !busy_r;
                     oe_nxt = shreg_r[7:4] == DEV_TYPE && !busy_r;
                     addr_hi_nxt = shreg_r[3:1];
                     rw_nxt = shreg_r[0];
                  end
                  ST_WRITE: begin
                     // A full FIFO refuses the byte with a no-acknowledge.
                     oe_nxt = fifo_ready;
                     push_nxt = fifo_ready;
                     push_word_nxt = '{first: nbytes_r == 2'h0, data: shreg_r};
                     if (nbytes_r != 2'h2) begin
                        nbytes_nxt = nbytes_r + 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end else if (ack_ph_r) begin
               ack_ph_nxt = 1'b0;
               oe_nxt = 1'b0;
               case (state_r)
                  ST_ADDR: begin
                     if (!ack_ok_r) begin
                        state_nxt = ST_STANDBY;
                     end else if (rw_r) begin
                        state_nxt = ST_READ;
                        shreg_nxt = tx_byte;
                        take_nxt = tx_valid;
                        oe_nxt = !tx_byte[7];
                     end else begin
                        state_nxt = ST_WRITE;
                        nbytes_nxt = '0;
                     end
                  end
                  ST_READ: begin
                     if (host_nack_r) begin
                        state_nxt = ST_STANDBY;
                     end else begin
                        shreg_nxt = tx_byte;
                        take_nxt = tx_valid;
                        oe_nxt = !tx_byte[7];
                     end
                  end
                  default: begin
                  end
               endcase
            end else if (state_r == ST_READ) begin
               shreg_nxt = {shreg_r[6:0], 1'b1};
               oe_nxt = !shreg_r[6];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_STANDBY;
         bitcnt_r <= '0;
         shreg_r <= '0;
         ack_ph_r <= 1'b0;
         oe_r <= 1'b0;
         ack_ok_r <= 1'b0;
         host_nack_r <= 1'b0;
         rw_r <= 1'b0;
         nbytes_r <= '0;
         addr_hi_r <= '0;
         busy_r <= 1'b0;
         wcnt_r <= '0;
         wstart_r <= 1'b0;
         take_r <= 1'b0;
         push_r <= 1'b0;
         push_word_r <= '0;
         out_valid_r <= 1'b0;
         out_word_r <= '0;
      end else begin
         state_r <= state_nxt;
         bitcnt_r <= bitcnt_nxt;
         shreg_r <= shreg_nxt;
         ack_ph_r <= ack_ph_nxt;
         oe_r <= oe_nxt;
         ack_ok_r <= ack_ok_nxt;
         host_nack_r <= host_nack_nxt;
         rw_r <= rw_nxt;
         nbytes_r <= nbytes_nxt;
         addr_hi_r <= addr_hi_nxt;
         busy_r <= busy_nxt;
         wcnt_r <= wcnt_nxt;
         wstart_r <= wstart_nxt;
         take_r <= take_nxt;
         push_r <= push_nxt;
         push_word_r <= push_word_nxt;
         out_valid_r <= out_valid_nxt;
         out_word_r <= out_word_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // The data pin only ever pulls low; the pull-up supplies the high level.
   logic low_r, low_nxt, standby_r, standby_nxt;
   always_comb begin
      low_nxt = 1'b0;
      standby_nxt = state_nxt == ST_STANDBY;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_r <= 1'b0;
         standby_r <= 1'b1;
      end else begin
         low_r <= low_nxt;
         standby_r <= standby_nxt;
      end
   end

   assign sda_out = low_r;
   assign sda_oe = oe_r;
   assign rx_valid = out_valid_r;
   assign rx_word = out_word_r;
   assign tx_take = take_r;
   assign write_busy = busy_r;
   assign write_start = wstart_r;
   assign standby = standby_r;
   assign read_mode = rw_r;
   assign addr_hi = addr_hi_r;
endmodule

`default_nettype wire

/* tb/eeprom_client_asserts.sv */
// Concurrent checks on the ports of the two-wire EEPROM client.
`timescale 1ns/100ps
`default_nettype none
module eeprom_client_asserts #(
   parameter int WRITE_CYCLES = 200
) (
   input wire logic clk, // Clock.
   input wire logic sys_rst, // Reset.
   input wire logic scl_in, // Bus clock.
   input wire logic sda_out, // Drive value.
   input wire logic sda_oe, // Drive enable.
   input wire logic rx_valid, // Word ready.
   input wire logic rx_ready, // Word taken.
   input wire eeprom_client_pkg::rx_word_t rx_word, // Word.
   input wire logic tx_take, // Read byte taken.
   input wire logic write_busy, // Write cycle.
   input wire logic write_start, // Write launch.
   input wire logic standby, // Standby.
   input wire logic read_mode // Read command.
);
   import eeprom_client_pkg::*;
   // ---------------------------------------------
   // Write cycle length
   // ---------------------------------------------
   int busy_cnt_r;
   int busy_cnt_nxt;
   always_comb busy_cnt_nxt = write_busy ? busy_cnt_r + 1 : 0;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) busy_cnt_r <= 0;
      else busy_cnt_r <= busy_cnt_nxt;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_od; sda_out == 1'b0; endproperty
   a_od: assert property (p_od) else $error("data line driven high");
   property p_rst; disable iff (1'b0) sys_rst |-> standby && !sda_oe; endproperty
   a_rst: assert property (p_rst) else $error("active during reset");
   property p_rise; $rose(sda_oe) |-> !scl_in; endproperty
   a_rise: assert property (p_rise) else $error("drive began with clock high");
   property p_fall; $fell(sda_oe) |-> !scl_in; endproperty
   a_fall: assert property (p_fall) else $error("release with clock high");
   property p_stby; standby |-> !sda_oe; endproperty
   a_stby: assert property (p_stby) else $error("drive in standby");
   property p_busy; write_busy |-> !sda_oe; endproperty
   a_busy: assert property (p_busy) else $error("answer during write cycle");
   property p_wst; write_start |-> !read_mode ##1 write_busy; endproperty
   a_wst: assert property (p_wst) else $error("write cycle not begun");
   property p_wlen;
      $fell(write_busy) |-> busy_cnt_r >= WRITE_CYCLES - 1 && busy_cnt_r <= WRITE_CYCLES + 1;
   endproperty
   a_wlen: assert property (p_wlen) else $error("write cycle length wrong");
   property p_take; tx_take |-> read_mode && !standby; endproperty
   a_take: assert property (p_take) else $error("read byte taken outside read");
   property p_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_word); endproperty
   a_hold: assert property (p_hold) else $error("word lost while stalled");
   c_wst: cover property (write_start);
   c_take: cover property (tx_take);
   c_full: cover property (rx_valid && !rx_ready);
endmodule
bind eeprom_client eeprom_client_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word), .tx_take(tx_take),
   .write_busy(write_busy), .write_start(write_start), .standby(standby),
   .read_mode(read_mode));
`default_nettype wire

/* tb/bus_host.sv */
// Behavioural two-wire bus host that makes the bus clock.
`timescale 1ns/100ps
`default_nettype none
module bus_host (
   output logic scl, // Bus clock.
   output logic sda_oe, // High while pulling data low.
   input wire logic sda // Resolved data line.
);
   // ---------------------------------------------
   // Bit and frame tasks
   // ---------------------------------------------
   localparam int Q = 40;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // Data moves a quarter bit into the low phase so it never changes while the clock is high.
   task automatic put_bit(input logic b, output logic s);
      scl = 1'b0;
      #Q sda_oe = !b;
      #Q scl = 1'b1;
      #(2*Q) s = sda;
      scl = 1'b0;
   endtask
   task automatic start();
      #Q sda_oe = 1'b0;
      #Q scl = 1'b1;
      #(2*Q) sda_oe = 1'b1;
      #(2*Q) scl = 1'b0;
   endtask
   task automatic stop();
      #Q sda_oe = 1'b1;
      #Q scl = 1'b1;
      #(2*Q) sda_oe = 1'b0;
      #(2*Q);
   endtask
   task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                       output logic ao);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], s);
         q[i] = s;
      end
      put_bit(ai, ao);
   endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench for the two-wire EEPROM client.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import eeprom_client_pkg::*;
   localparam int WC = 400;
   localparam logic [3:0] DT = 4'h5; // Arbitrary type value.
   logic clk = 1'b0, sys_rst, rx_ready = 1'b0, tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic scl, h_oe, sda, sda_out, sda_oe, rx_valid, tx_take, write_busy, write_start;
   logic standby, read_mode;
   logic [2:0] addr_hi;
   rx_word_t rx_word;
   int err_count = 0, n_compared = 0;
   int n_take = 0, n_wstart = 0;
   always @(posedge clk) begin
      if (tx_take === 1'b1) n_take <= n_take + 1;
      if (write_start === 1'b1) n_wstart <= n_wstart + 1;
   end
   logic [31:0] rng = 32'h1a3f;
   always #5 clk = ~clk;
   assign sda = !((sda_oe && !sda_out) || h_oe);
   bus_host host (.scl(scl), .sda_oe(h_oe), .sda(sda));
   eeprom_client #(.WRITE_CYCLES(WC), .DEV_TYPE(DT)) u_eeprom_client (
      .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take), .write_busy(write_busy),
      .write_start(write_start), .standby(standby), .read_mode(read_mode),
      .addr_hi(addr_hi));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] ab(input logic [3:0] t, input logic [2:0] a, input logic r);
      return {t, a, r};
   endfunction
   task automatic end_sim();
      $display("mismatches=%0d compares=%0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_f(input logic got, input logic exp);
      cmp({8'h00, got}, {8'h00, exp});
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wb(input logic [7:0] d, input logic nack);
      logic [7:0] q;
      logic a;
      host.xfer(d, 1'b1, q, a);
      cmp_f(a, nack);
   endtask
   initial begin
      #400000;
      err_count++;
      end_sim();
   end
   initial begin
      logic [7:0] q, d;
      logic a;
      int n, k;
      logic [8:0] exp_q[$];
      // Reset must rise from unknown so that the asynchronous reset branches run.
      sys_rst = 1'b1;
      step(16);
      cmp_f(standby, 1'b1);
      cmp_f(sda_oe, 1'b0);
      sys_rst = 1'b0;
      step(10000);
      host.xfer(ab(DT, 3'b101, 1'b0), 1'b1, q, a);
      cmp_f(a, 1'b1);
      host.start();
      for (n = 0; n < 3; n++) host.put_bit(1'b0, a);
      host.start();
      wb(ab(DT, 3'b101, 1'b0), 1'b0);
      cmp_f(read_mode, 1'b0);
      cmp({6'h00, addr_hi}, 9'h005);
      // Buffer and output stage hold seventeen words, so the eighteenth meets a full buffer.
      for (n = 0; n < 18; n++) begin
         d = rng[7:0];
         rng = xs(rng);
         if (n < 17) exp_q.push_back({n == 0, d});
         wb(d, n == 17);
      end
      host.stop();
      step(3);
      cmp_f(write_busy, 1'b1);
      host.start();
      wb(ab(DT, 3'b101, 1'b0), 1'b1);
      host.stop();
      k = 0;
      for (n = 0; n < 400 && k < 17; n++) begin
         step(1);
         rx_ready = rng[0];
         rng = xs(rng);
         if (rx_ready && rx_valid) begin
            cmp(rx_word, exp_q[k]);
            k++;
         end
      end
      if (k < 17) err_count++;
      step(1);
      cmp_f(rx_valid, 1'b0);
      for (n = 0; n < WC + 50 && write_busy === 1'b1; n++) @(posedge clk);
      if (n == WC + 50) begin
         err_count++;
         end_sim();
      end
      step(1);
      cmp_f(standby, 1'b1);
      host.start();
      wb(ab(DT ^ 4'h1, 3'b000, 1'b0), 1'b1);
      step(8);
      cmp_f(standby, 1'b1);
      host.stop();
      rx_ready = 1'b1;
      tx_data = rng[7:0];
      tx_valid = 1'b1;
      host.start();
      wb(ab(DT, 3'b010, 1'b0), 1'b0);
      wb(8'h3c, 1'b0);
      host.start();
      wb(ab(DT, 3'b010, 1'b1), 1'b0);
      cmp_f(read_mode, 1'b1);
      host.xfer(8'hff, 1'b0, q, a);
      tx_valid = 1'b0;
      cmp({1'b0, q}, {1'b0, tx_data});
      host.xfer(8'hff, 1'b1, q, a);
      cmp({1'b0, q}, 9'h0ff);
      step(8);
      cmp_f(standby, 1'b1);
      cmp_f(sda_oe, 1'b0);
      host.stop();
      cmp(9'(n_take), 9'h001);
      cmp(9'(n_wstart), 9'h001);
      end_sim();
   end
endmodule
`default_nettype wire
